// file: rtl/exec_core.sv
// Execute stage for a subset of an 8-bit core's instructions.
// Assumes a decoder presents one operation with its operands when
// issue_valid_i is high and ready_o is high; file register data is read
// combinationally by the surrounding core and presented on file_data_i.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module exec_core
    import exec_pkg::*;
#(
    parameter int DATA_W = `DATA_W,
    parameter int FADDR_W = `FADDR_W,
    parameter int PC_W = `PC_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic issue_valid_i,
    input wire logic [3:0] issue_op_i,
    input wire logic [DATA_W-1:0] literal_i,
    input wire logic [FADDR_W-1:0] file_addr_i,
    input wire logic dest_i,
    input wire logic [DATA_W-1:0] file_data_i,
    input wire logic [PC_W-1:0] stack_top_i,
    input wire logic wake_i,
    output logic ready_o,
    output logic [DATA_W-1:0] accumulator_o,
    output logic [7:0] status_o,
    output logic global_interrupt_enable_o,
    output logic file_we_o,
    output logic [FADDR_W-1:0] file_waddr_o,
    output logic [DATA_W-1:0] file_wdata_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_value_o,
    output logic stack_pop_o,
    output logic watchdog_clear_o,
    output logic sleeping_o
);
    exec_state_e state_reg;
    exec_state_e state_next;
    logic [DATA_W-1:0] acc_reg;
    logic [7:0] status_reg;
    logic gie_reg;
    logic file_we_reg;
    logic [FADDR_W-1:0] file_waddr_reg;
    logic [DATA_W-1:0] file_wdata_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_value_reg;
    logic stack_pop_reg;
    logic wdt_clear_reg;
    logic [`WDT_W-1:0] watchdog_counter_reg;
    logic [`PRESCALE_W-1:0] prescale_reg;

    logic take;
    exec_op_e op;
    logic [DATA_W-1:0] sub_a;
    logic [DATA_W-1:0] sub_diff;
    logic sub_c;
    logic sub_dc;
    logic [DATA_W-1:0] rot_result;
    logic rot_c;
    logic [DATA_W-1:0] result;
    logic writes_result;
    logic sets_z;
    logic sets_cdc;

    assign op = exec_op_e'(issue_op_i);
    assign take = issue_valid_i && (state_reg == ST_READY);
    assign ready_o = (state_reg == ST_READY);

    // Literal subtract uses the immediate; file subtract uses the file data.
    assign sub_a = (op == OP_SUB_LIT) ? literal_i : file_data_i;

    exec_subtract #(
        .WIDTH(DATA_W)
    ) u_subtract (
        .a_i(sub_a),
        .b_i(acc_reg),
        .diff_o(sub_diff),
        .carry_o(sub_c),
        .digit_carry_o(sub_dc)
    );

    exec_rotate #(
        .WIDTH(DATA_W)
    ) u_rotate (
        .value_i(file_data_i),
        .carry_i(status_reg[`STATUS_C_BIT]),
        .left_i(op == OP_ROT_LEFT),
        .result_o(rot_result),
        .carry_o(rot_c)
    );

    always_comb
    begin
        result = acc_reg;
        writes_result = 1'b0;
        sets_z = 1'b0;
        sets_cdc = 1'b0;
        case (op)
            OP_LOAD_LIT, OP_RET_LIT:
            begin
                result = literal_i;
                writes_result = 1'b1;
            end
            OP_ROT_LEFT, OP_ROT_RIGHT:
            begin
                result = rot_result;
                writes_result = 1'b1;
            end
            OP_SUB_LIT, OP_SUB_FILE:
            begin
                result = sub_diff;
                writes_result = 1'b1;
                sets_z = 1'b1;
                sets_cdc = 1'b1;
            end
            OP_SWAP:
            begin
                result = {file_data_i[3:0], file_data_i[7:4]};
                writes_result = 1'b1;
            end
            OP_XOR_FILE:
            begin
                result = acc_reg ^ file_data_i;
                writes_result = 1'b1;
                sets_z = 1'b1;
            end
            OP_XOR_LIT:
            begin
                result = acc_reg ^ literal_i;
                writes_result = 1'b1;
                sets_z = 1'b1;
            end
            default:
            begin
                result = acc_reg;
            end
        endcase
    end

    // Literal-only operations always target the accumulator.
    function automatic logic to_file(input exec_op_e o, input logic d);
        case (o)
            OP_ROT_LEFT, OP_ROT_RIGHT, OP_SUB_FILE, OP_SWAP, OP_XOR_FILE:
                to_file = d;
            default:
                to_file = 1'b0;
        endcase
    endfunction : to_file

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_READY:
            begin
                if (take && (op == OP_RET_LIT ||
                    op == OP_RETURN))
                begin
                    state_next = ST_SECOND;
                end
                else if (take && op == OP_SLEEP)
                begin
                    state_next = ST_SLEEP;
                end
                else
                begin
                    state_next = ST_READY;
                end
            end
            ST_SECOND:
            begin
                state_next = ST_READY;
            end
            ST_SLEEP:
            begin
                if (wake_i)
                begin
                    state_next = ST_READY;
                end
            end
            default:
            begin
                state_next = ST_READY;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= ST_READY;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Accumulator updates only when the destination is the accumulator.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            acc_reg <= `ACC_RESET;
        end
        else if (take && writes_result && !to_file(op, dest_i))
        begin
            acc_reg <= result;
        end
    end

    // File writes are one-cycle pulses with registered address and data.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            file_we_reg <= 1'b0;
            file_waddr_reg <= '0;
            file_wdata_reg <= '0;
        end
        else
        begin
            file_we_reg <= 1'b0;
            if (take && op == OP_STORE_ACC)
            begin
                file_we_reg <= 1'b1;
                file_waddr_reg <= file_addr_i;
                file_wdata_reg <= acc_reg;
            end
            else if (take && writes_result && to_file(op, dest_i))
            begin
                file_we_reg <= 1'b1;
                file_waddr_reg <= file_addr_i;
                file_wdata_reg <= result;
            end
        end
    end

    // Status flags: only the listed operations touch them.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            status_reg <= `STATUS_RESET;
        end
        else if (take)
        begin
            if (op == OP_ROT_LEFT || op == OP_ROT_RIGHT)
            begin
                status_reg[`STATUS_C_BIT] <= rot_c;
            end
            if (sets_cdc)
            begin
                status_reg[`STATUS_C_BIT] <= sub_c;
                status_reg[`STATUS_DC_BIT] <= sub_dc;
            end
            if (sets_z)
            begin
                status_reg[`STATUS_Z_BIT] <= (result == '0);
            end
            if (op == OP_SLEEP)
            begin
                status_reg[`STATUS_PD_BIT] <= 1'b0;
                status_reg[`STATUS_TO_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            gie_reg <= 1'b0;
        end
        else if (take && op == OP_RET_INT)
        begin
            gie_reg <= 1'b1;
        end
    end

    // Program counter reload and stack pop for the returns.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            pc_load_reg <= 1'b0;
            pc_value_reg <= '0;
            stack_pop_reg <= 1'b0;
        end
        else
        begin
            pc_load_reg <= 1'b0;
            stack_pop_reg <= 1'b0;
            if (take && (op == OP_RET_INT || op == OP_RET_LIT ||
                op == OP_RETURN))
            begin
                pc_load_reg <= 1'b1;
                pc_value_reg <= stack_top_i;
                stack_pop_reg <= 1'b1;
            end
        end
    end

    // The watchdog counter and prescaler live here so sleep can clear them;
    // they stop while the oscillator is notionally halted.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            watchdog_counter_reg <= `WDT_CLEAR;
            prescale_reg <= '0;
            wdt_clear_reg <= 1'b0;
        end
        else
        begin
            wdt_clear_reg <= 1'b0;
            if (take && op == OP_SLEEP)
            begin
                watchdog_counter_reg <= `WDT_CLEAR;
                prescale_reg <= '0;
                wdt_clear_reg <= 1'b1;
            end
            else if (state_reg != ST_SLEEP)
            begin
                prescale_reg <= prescale_reg + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
                if (prescale_reg == '1)
                begin
                    watchdog_counter_reg <= watchdog_counter_reg +
                        {{(`WDT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign accumulator_o = acc_reg;
    assign status_o = status_reg;
    assign global_interrupt_enable_o = gie_reg;
    assign file_we_o = file_we_reg;
    assign file_waddr_o = file_waddr_reg;
    assign file_wdata_o = file_wdata_reg;
    assign pc_load_o = pc_load_reg;
    assign pc_value_o = pc_value_reg;
    assign stack_pop_o = stack_pop_reg;
    assign watchdog_clear_o = wdt_clear_reg;
    assign sleeping_o = (state_reg == ST_SLEEP);
endmodule : exec_core
`default_nettype wire

// file: rtl/exec_defs.svh
// Constants for the instruction execute subset: bus widths, flag bits
// and reset values. Included by every design file that needs them.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define FADDR_W 7
`define DATA_W 8
`define PC_W 13
`define STATUS_C_BIT 0
`define STATUS_DC_BIT 1
`define STATUS_Z_BIT 2
`define STATUS_PD_BIT 3
`define STATUS_TO_BIT 4
`define STATUS_RESET 8'h18
`define ACC_RESET 8'h00
`define WDT_CLEAR 8'h00
`define WDT_W 8
`define PRESCALE_W 8

`endif

// file: rtl/exec_pkg.sv
// Types shared by the execute subset: operation codes and cycle states.
// Assumes nothing of its surroundings.
package exec_pkg;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_LOAD_LIT = 4'h1,
        OP_RET_INT = 4'h2,
        OP_STORE_ACC = 4'h3,
        OP_RET_LIT = 4'h4,
        OP_ROT_LEFT = 4'h5,
        OP_ROT_RIGHT = 4'h6,
        OP_SLEEP = 4'h7,
        OP_RETURN = 4'h8,
        OP_SUB_LIT = 4'h9,
        OP_SUB_FILE = 4'ha,
        OP_SWAP = 4'hb,
        OP_XOR_FILE = 4'hc,
        OP_XOR_LIT = 4'hd
    } exec_op_e;

    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_SECOND = 2'b01,
        ST_SLEEP = 2'b10
    } exec_state_e;

endpackage : exec_pkg

// file: rtl/exec_rotate.sv
// Rotate through carry by one bit, left or right.
// Purely combinational; the caller latches the result.
`timescale 1ns/1ps
`default_nettype none
module exec_rotate #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] value_i,
    input wire logic carry_i,
    input wire logic left_i,
    output logic [WIDTH-1:0] result_o,
    output logic carry_o
);
    always_comb
    begin
        if (left_i)
        begin
            result_o = {value_i[WIDTH-2:0], carry_i};
            carry_o = value_i[WIDTH-1];
        end
        else
        begin
            result_o = {carry_i, value_i[WIDTH-1:1]};
            carry_o = value_i[0];
        end
    end
endmodule : exec_rotate
`default_nettype wire

// file: rtl/exec_subtract.sv
// Eight-bit subtractor a - b with carry and digit carry.
// Carry and digit carry are active-high "no borrow", as the core expects.
`timescale 1ns/1ps
`default_nettype none
module exec_subtract #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] a_i,
    input wire logic [WIDTH-1:0] b_i,
    output logic [WIDTH-1:0] diff_o,
    output logic carry_o,
    output logic digit_carry_o
);
    logic [WIDTH:0] full;
    logic [4:0] low;

    // Two's complement: a + ~b + 1, carry out means no borrow.
    assign full = {1'b0, a_i} + {1'b0, ~b_i} + {{WIDTH{1'b0}}, 1'b1};
    assign low = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
    assign diff_o = full[WIDTH-1:0];
    assign carry_o = full[WIDTH];
    assign digit_carry_o = low[4];
endmodule : exec_subtract
`default_nettype wire

// file: verif/exec_core_bench.sv
// Bench for exec_core: directed scenarios, one task each.
// Drives every input itself; the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module exec_core_bench
    import exec_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic issue_valid_i = 1'b0;
    logic [3:0] issue_op_i = 4'h0;
    logic [7:0] literal_i = 8'h00;
    logic [6:0] file_addr_i = 7'h00;
    logic dest_i = 1'b0;
    logic [7:0] file_data_i = 8'h00;
    logic [12:0] stack_top_i = 13'h1abc;
    logic wake_i = 1'b0;
    logic ready_o, global_interrupt_enable_o, file_we_o, pc_load_o;
    logic stack_pop_o, watchdog_clear_o, sleeping_o;
    logic [7:0] accumulator_o, status_o, file_wdata_o;
    logic [6:0] file_waddr_o;
    logic [12:0] pc_value_o;
    int err_count = 0;
    int check_count = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    exec_core DUT (.clk_sys_i, .rst_b_i, .issue_valid_i, .issue_op_i,
        .literal_i, .file_addr_i, .dest_i, .file_data_i, .stack_top_i,
        .wake_i, .ready_o, .accumulator_o, .status_o,
        .global_interrupt_enable_o, .file_we_o, .file_waddr_o,
        .file_wdata_o, .pc_load_o, .pc_value_o, .stack_pop_o,
        .watchdog_clear_o, .sleeping_o);

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // The literal doubles as file address so one argument serves both.
    task automatic run(input logic [3:0] op, input logic [7:0] lit,
        input logic d, input logic [7:0] fd);
        @(posedge clk_sys_i);
        issue_valid_i <= 1'b1;
        issue_op_i <= op;
        literal_i <= lit;
        file_addr_i <= lit[6:0];
        dest_i <= d;
        file_data_i <= fd;
        @(posedge clk_sys_i);
        issue_valid_i <= 1'b0;
        #1;
    endtask : run

    task automatic t_literal();
        run(OP_LOAD_LIT, 8'hff, 1'b0, 8'h00);
        chk(ready_o, 1'b1);
        chk({accumulator_o, status_o}, 16'hff18);
        run(OP_XOR_LIT, 8'hff, 1'b0, 8'h00);
        chk({accumulator_o, status_o}, 16'h001c);
        run(OP_XOR_LIT, 8'h81, 1'b0, 8'h00);
        chk({accumulator_o, status_o}, 16'h8118);
    endtask : t_literal

    task automatic t_sub();
        run(OP_LOAD_LIT, 8'h03, 1'b0, 8'h00);
        run(OP_SUB_LIT, 8'h05, 1'b0, 8'h00);
        chk({accumulator_o, status_o}, 16'h021b);
        run(OP_LOAD_LIT, 8'h06, 1'b0, 8'h00);
        run(OP_SUB_LIT, 8'h05, 1'b0, 8'h00);
        chk({accumulator_o, status_o}, 16'hff18);
        run(OP_SUB_FILE, 8'h10, 1'b1, 8'hff);
        chk({file_we_o, file_waddr_o}, 16'h0090);
        chk({file_wdata_o, accumulator_o}, 16'h00ff);
        chk(status_o, 8'h1f);
        run(OP_SUB_FILE, 8'h00, 1'b0, 8'h10);
        chk(file_we_o, 1'b0);
        chk({accumulator_o, status_o}, 16'h1118);
    endtask : t_sub

    task automatic t_rotate();
        run(OP_ROT_LEFT, 8'h00, 1'b0, 8'h81);
        chk({accumulator_o, status_o}, 16'h0219);
        run(OP_ROT_LEFT, 8'h00, 1'b0, 8'h01);
        chk({accumulator_o, status_o}, 16'h0318);
        run(OP_ROT_RIGHT, 8'h20, 1'b1, 8'h01);
        chk({file_we_o, file_wdata_o}, 16'h0100);
        chk({accumulator_o, status_o}, 16'h0319);
        run(OP_ROT_RIGHT, 8'h00, 1'b0, 8'h02);
        chk({accumulator_o, status_o}, 16'h8118);
    endtask : t_rotate

    task automatic t_file();
        run(OP_STORE_ACC, 8'h7f, 1'b0, 8'h00);
        chk({file_we_o, file_waddr_o, file_wdata_o}, 16'hff81);
        chk(status_o, 8'h18);
        run(OP_SWAP, 8'h00, 1'b0, 8'h5a);
        chk({accumulator_o, status_o}, 16'ha518);
        run(OP_SWAP, 8'h05, 1'b1, 8'h3c);
        chk({file_we_o, file_wdata_o}, 16'h01c3);
        run(OP_XOR_FILE, 8'h01, 1'b1, 8'ha5);
        chk({file_wdata_o, status_o}, 16'h001c);
        run(OP_XOR_FILE, 8'h00, 1'b0, 8'h0f);
        chk({accumulator_o, status_o}, 16'haa18);
    endtask : t_file

    // The interrupt return is not a two-cycle operation, so ready stays up.
    task automatic t_returns();
        chk(global_interrupt_enable_o, 1'b0);
        run(OP_RET_INT, 8'h00, 1'b0, 8'h00);
        chk({pc_load_o, ready_o}, 2'h3);
        chk(global_interrupt_enable_o, 1'b1);
        chk({status_o, 3'h0, pc_value_o}, 24'h18_1abc);
        @(posedge clk_sys_i);
        stack_top_i <= 13'h0123;
        run(OP_RET_LIT, 8'h3c, 1'b0, 8'h00);
        chk({pc_load_o, ready_o, accumulator_o}, 10'h23c);
        run(OP_RETURN, 8'h00, 1'b0, 8'h00);
        chk({stack_pop_o, pc_load_o, ready_o}, 3'h6);
        chk(pc_value_o, 13'h0123);
        @(posedge clk_sys_i);
        #1;
        chk({ready_o, status_o}, 9'h118);
    endtask : t_returns

    task automatic t_sleep();
        run(OP_SLEEP, 8'h00, 1'b0, 8'h00);
        chk({watchdog_clear_o, sleeping_o, ready_o}, 3'h6);
        chk(status_o, 8'h10);
        run(OP_LOAD_LIT, 8'h77, 1'b0, 8'h00);
        chk(accumulator_o, 8'h3c);
        @(posedge clk_sys_i);
        wake_i <= 1'b1;
        @(posedge clk_sys_i);
        wake_i <= 1'b0;
        #1;
        chk({sleeping_o, ready_o}, 2'h1);
        run(OP_LOAD_LIT, 8'h77, 1'b0, 8'h00);
        chk({accumulator_o, status_o}, 16'h7710);
    endtask : t_sleep

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        t_literal();
        t_sub();
        t_rotate();
        t_file();
        t_returns();
        t_sleep();
        wrap_up();
    end

    // The scenarios need about 60 cycles; this leaves ample margin.
    initial
    begin
        repeat (600) @(posedge clk_sys_i);
        err_count++;
        wrap_up();
    end
endmodule : exec_core_bench
`default_nettype wire

// file: verif/exec_core_checker.sv
// Checker for the execute subset: ties the literal, store, return, sleep and swap-to-file operations to their results.
// Sees only exec_core ports; bound into every exec_core below.
`timescale 1ns/1ps
`default_nettype none
module exec_core_checker
    import exec_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int FADDR_W = 7,
    parameter int PC_W = 13
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic issue_valid_i,
    input wire logic [3:0] issue_op_i,
    input wire logic [DATA_W-1:0] literal_i,
    input wire logic [FADDR_W-1:0] file_addr_i,
    input wire logic dest_i,
    input wire logic [DATA_W-1:0] file_data_i,
    input wire logic [PC_W-1:0] stack_top_i,
    input wire logic ready_o,
    input wire logic [DATA_W-1:0] accumulator_o,
    input wire logic [7:0] status_o,
    input wire logic global_interrupt_enable_o,
    input wire logic file_we_o,
    input wire logic [FADDR_W-1:0] file_waddr_o,
    input wire logic [DATA_W-1:0] file_wdata_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_value_o,
    input wire logic stack_pop_o,
    input wire logic watchdog_clear_o,
    input wire logic sleeping_o
);
    wire logic take;
    assign take = issue_valid_i && ready_o;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    load_lit_a: assert property (
        take && issue_op_i == OP_LOAD_LIT |=> accumulator_o == $past(literal_i)
        && status_o == $past(status_o)) else $error("load literal wrong");
    ret_int_a: assert property (
        take && issue_op_i == OP_RET_INT |=> pc_load_o && ready_o
        && pc_value_o == $past(stack_top_i) && global_interrupt_enable_o)
        else $error("interrupt return wrong");
    store_acc_a: assert property (
        take && issue_op_i == OP_STORE_ACC |=> file_we_o
        && file_wdata_o == $past(accumulator_o)
        && file_waddr_o == $past(file_addr_i)) else $error("store wrong");
    ret_lit_a: assert property (
        take && issue_op_i == OP_RET_LIT |=> accumulator_o == $past(literal_i)
        && pc_load_o && !ready_o ##1 ready_o)
        else $error("literal return wrong");
    sleep_entry_a: assert property (
        take && issue_op_i == OP_SLEEP |=> watchdog_clear_o && sleeping_o
        && status_o[4:3] == 2'h2 && status_o[2:0] == $past(status_o[2:0]))
        else $error("sleep entry wrong");
    return_pop_a: assert property (
        take && issue_op_i == OP_RETURN |=> stack_pop_o && pc_load_o
        && status_o == $past(status_o) && !ready_o ##1 ready_o)
        else $error("return wrong");
    sub_lit_a: assert property (
        take && issue_op_i == OP_SUB_LIT |=> accumulator_o ==
        $past(literal_i) - $past(accumulator_o)
        && status_o[0] == ($past(literal_i) >= $past(accumulator_o)))
        else $error("subtract literal wrong");
    swap_file_a: assert property (
        take && issue_op_i == OP_SWAP && dest_i |=> file_we_o && file_wdata_o
        == {$past(file_data_i[3:0]), $past(file_data_i[7:4])})
        else $error("swap to file wrong");
    xor_lit_a: assert property (
        take && issue_op_i == OP_XOR_LIT |=> accumulator_o ==
        ($past(accumulator_o) ^ $past(literal_i))
        && status_o[2] == (accumulator_o == '0)
        && status_o[1:0] == $past(status_o[1:0]))
        else $error("xor literal wrong");
    one_cycle_a: assert property (
        take && !(issue_op_i inside {OP_RET_LIT, OP_RETURN,
        OP_SLEEP}) |=> ready_o) else $error("single cycle op stalled");
endmodule : exec_core_checker

bind exec_core exec_core_checker #(.DATA_W(DATA_W), .FADDR_W(FADDR_W),
    .PC_W(PC_W)) u_checker (.clk_sys_i, .rst_b_i, .issue_valid_i,
    .issue_op_i, .literal_i, .file_addr_i, .dest_i, .file_data_i,
    .stack_top_i, .ready_o, .accumulator_o, .status_o,
    .global_interrupt_enable_o, .file_we_o, .file_waddr_o, .file_wdata_o,
    .pc_load_o, .pc_value_o, .stack_pop_o, .watchdog_clear_o, .sleeping_o);
`default_nettype wire
